/* File: include/gptmr_regs.vh */
// register offsets, field positions and reset values of the general purpose timer/counter
`ifndef GPTMR_REGS_VH
`define GPTMR_REGS_VH

// byte offsets (word aligned, 8-bit address)
`define GPT_ADDR_CTRL      8'h00
`define GPT_ADDR_COUNT     8'h04
`define GPT_ADDR_PRESCALE  8'h08
`define GPT_ADDR_PRECNT    8'h0C
`define GPT_ADDR_MATCHCTL  8'h10
`define GPT_ADDR_CAPCTL    8'h14
`define GPT_ADDR_EXTCTL    8'h18
`define GPT_ADDR_PWMCTL    8'h1C
`define GPT_ADDR_STATUS    8'h20
`define GPT_ADDR_MASK      8'h24
`define GPT_ADDR_MATCH0    8'h30
`define GPT_ADDR_CAPT0     8'h40

// control register fields
`define GPT_CTRL_ENABLE    0
`define GPT_CTRL_RESET     1
`define GPT_CTRL_MODE_LO   2
`define GPT_CTRL_MODE_HI   3
`define GPT_CTRL_CLRSEL_LO 4
`define GPT_CTRL_CLRSEL_HI 6

// count source modes
`define GPT_MODE_TIMER     2'h0
`define GPT_MODE_RISE      2'h1
`define GPT_MODE_FALL      2'h2
`define GPT_MODE_BOTH      2'h3

// external output actions
`define GPT_EXT_NONE       2'h0
`define GPT_EXT_LOW        2'h1
`define GPT_EXT_HIGH       2'h2
`define GPT_EXT_TOGGLE     2'h3

// status bit positions: match 0..3, capture 4..7
`define GPT_STAT_CAP_BASE  4

// reset values
`define GPT_RST_WORD       32'h0000_0000
`define GPT_RST_MATCH      32'hFFFF_FFFF

`endif

/* File: rtl/gptmr_top.v */
// general purpose 32-bit timer/counter with prescaler, capture, match, pwm and dma requests
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "gptmr_regs.vh"

// register map, byte offsets on an 8-bit address:
//   00 control: [0] run, [1] hold counter and prescaler at zero,
//      [3:2] count source, [6:4] clear-on-capture select (1..4, 0 off)
//   04 count (read only)       08 prescale value
//   0C prescale count (ro)     10 match control, 3 bits per match:
//      irq, reset, stop
//   14 capture control, 3 bits per input: rise, fall, irq
//   18 output action, 2 bits per match: none, low, high, toggle
//   1C pwm enable [3:0], dma enable [9:8] for matches 0 and 1
//   20 status, write one to clear: [3:0] match, [7:4] capture
//   24 interrupt mask, same layout as status
//   30..3C match shadows (read back the shadow, not the live value)
//   40..4C capture registers (read only)
// unmapped addresses ignore writes; they read zero except in 30..3F and 40..4F, where bits [3:2] pick the word.
// clock enable low freezes every register, read data included.
// counting: in timer mode the prescale counter steps every cycle; when it
// equals the prescale value it wraps and the main count steps, so the
// count rate is the tick rate over (prescale + 1).
// pwm, channels 0..2: the output rises on its own match and falls at the
// period boundary; use match 3 with reset-on-match as the period.
// a duty change written mid-period waits in the shadow until the boundary.
// stop-on-match clears the run bit; a write to control in that cycle loses.
// status set wins over a write-one-to-clear in the same cycle.
// limitation: pin edges are seen three cycles late and a pin level must
// last longer than one clock period, or the edge may be lost.

module gptmr_top #(
  parameter NCAP = 4,
  parameter NMAT = 4
) (
  // clock, reset, enable
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clk_en,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // pins
  input  wire        ext_clk,
  input  wire [3:0]  cap_in,
  output reg  [3:0]  match_out,
  // system
  output reg  [1:0]  dma_req,
  output reg         irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [31:0] count;
  reg  [31:0] prescale;
  reg  [31:0] precnt;
  reg  [6:0]  ctrl;
  reg  [11:0] match_ctl;      // per match: irq, reset, stop
  reg  [11:0] cap_ctl;        // per capture: rise, fall, irq
  reg  [7:0]  ext_ctl;        // per match: 2-bit output action
  reg  [3:0]  pwm_ctl;        // per match: pwm enable
  reg  [1:0]  dma_en;
  reg  [7:0]  status;
  reg  [7:0]  mask;
  reg  [31:0] match_val [0:3];
  reg  [31:0] match_shd [0:3];
  reg  [31:0] capt      [0:3];

  // synchronisers for pins
  reg  [4:0]  pin_s1;
  reg  [4:0]  pin_s2;
  reg  [4:0]  pin_d;

  // one loop variable per process, so no two processes share a driver
  integer i_cap;
  integer i_hit;
  integer i_cnt;
  integer i_reg;
  integer i_out;

  // bank decode for indexed banks, shared by write strobes and reads
  function is_bank;
    input [7:0] addr;
    input [7:0] base;
    begin
      is_bank = (addr[7:4] == base[7:4]);
    end
  endfunction

  // picks bit off of each 3-bit per-channel field, channel 0 in bit 0
  function [3:0] pick3;
    input [11:0] field;
    input [1:0]  off;
    integer      k;
    begin
      for (k = 0; k < 4; k = k + 1)
        pick3[k] = field[3*k + off];
    end
  endfunction

  // ----------------------------------------------------------------
  // pin sampling and edge detect
  // ----------------------------------------------------------------
  // two flops before any logic, third flop for edge history;
  // all reset low, the idle level of the pins, so no false edge follows reset
  always @(posedge clk_sys) begin
    if (reset) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_d  <= 5'h00;
    end else if (clk_en) begin
      pin_s1 <= {ext_clk, cap_in};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  wire [4:0] rise = pin_s2 & ~pin_d;
  wire [4:0] fall = ~pin_s2 & pin_d;

  // ----------------------------------------------------------------
  // count source and prescaler
  // ----------------------------------------------------------------
  wire [1:0] mode    = ctrl[`GPT_CTRL_MODE_HI:`GPT_CTRL_MODE_LO];
  wire       running = ctrl[`GPT_CTRL_ENABLE] & ~ctrl[`GPT_CTRL_RESET];
  reg        tick_src;

  // timer counts every cycle, counter counts sampled external edges
  always @* begin
    case (mode)
      `GPT_MODE_TIMER: tick_src = 1'b1;
      `GPT_MODE_RISE:  tick_src = rise[4];
      `GPT_MODE_FALL:  tick_src = fall[4];
      `GPT_MODE_BOTH:  tick_src = rise[4] | fall[4];
      default:         tick_src = 1'b0;
    endcase
  end

  wire pre_wrap = running & tick_src & (precnt == prescale);

  // ----------------------------------------------------------------
  // capture events
  // ----------------------------------------------------------------
  reg [3:0] cap_evt;
  always @* begin
    for (i_cap = 0; i_cap < 4; i_cap = i_cap + 1)
      cap_evt[i_cap] = (cap_ctl[3*i_cap] & rise[i_cap]) | (cap_ctl[3*i_cap+1] & fall[i_cap]);
  end

  // clear-on-capture: field value 1..4 selects capture 0..3, 0 is off;
  // the clear shares the capture's own edge, so the captured value is the
  // count reached just before the clear
  wire [2:0] clrsel   = ctrl[`GPT_CTRL_CLRSEL_HI:`GPT_CTRL_CLRSEL_LO];
  wire       cap_clr  = (clrsel != 3'h0) & (clrsel <= 3'h4) & cap_evt[clrsel[1:0] - 2'h1];

  // ----------------------------------------------------------------
  // match detect
  // ----------------------------------------------------------------
  // a match is raised on the compare while the counter is moving;
  // comparing the value about to leave makes a reset period match+1 count steps
  reg [3:0] hit;
  always @* begin
    for (i_hit = 0; i_hit < 4; i_hit = i_hit + 1)
      hit[i_hit] = pre_wrap & (count == match_val[i_hit]);
  end

  // the period boundary is either a reset match or the natural wrap
  wire any_rst  = |(hit & pick3(match_ctl, 2'h1));
  wire any_stop = |(hit & pick3(match_ctl, 2'h2));
  wire period   = any_rst | (pre_wrap & (count == 32'hFFFF_FFFF));

  // ----------------------------------------------------------------
  // counter, prescaler, shadow reload
  // ----------------------------------------------------------------
  // a running pwm channel's shadow loads only at the period boundary, so a duty change never
  // lands mid-period and produces a runt pulse
  always @(posedge clk_sys) begin
    if (reset) begin
      count  <= `GPT_RST_WORD;
      precnt <= `GPT_RST_WORD;
      for (i_cnt = 0; i_cnt < 4; i_cnt = i_cnt + 1)
        match_val[i_cnt] <= `GPT_RST_MATCH;
    end else if (clk_en) begin
      // hold and clear-on-capture outrank counting, so a clearing capture
      // also beats a match in the same cycle
      if (ctrl[`GPT_CTRL_RESET] | cap_clr) begin
        count  <= `GPT_RST_WORD;
        precnt <= `GPT_RST_WORD;
      end else if (running & tick_src) begin
        if (pre_wrap) begin
          precnt <= `GPT_RST_WORD;
          if (any_rst)
            count <= `GPT_RST_WORD;
          else
            count <= count + 32'h0000_0001;
        end else begin
          precnt <= precnt + 32'h0000_0001;
        end
      end
      for (i_cnt = 0; i_cnt < 4; i_cnt = i_cnt + 1)
        if (period | ~running | ~pwm_ctl[i_cnt])
          match_val[i_cnt] <= match_shd[i_cnt];
    end
  end

  // ----------------------------------------------------------------
  // register writes and hardware updates of control state
  // ----------------------------------------------------------------
  wire       wr_stat  = reg_wr & (reg_addr == `GPT_ADDR_STATUS);
  wire [7:0] evt_bits = {cap_evt & pick3(cap_ctl, 2'h2), hit & pick3(match_ctl, 2'h0)};

  always @(posedge clk_sys) begin
    if (reset) begin
      ctrl      <= 7'h00;
      prescale  <= `GPT_RST_WORD;
      match_ctl <= 12'h000;
      cap_ctl   <= 12'h000;
      ext_ctl   <= 8'h00;
      pwm_ctl   <= 4'h0;
      dma_en    <= 2'h0;
      mask      <= 8'h00;
      status    <= 8'h00;
      for (i_reg = 0; i_reg < 4; i_reg = i_reg + 1) begin
        match_shd[i_reg] <= `GPT_RST_MATCH;
        capt[i_reg]      <= `GPT_RST_WORD;
      end
    end else if (clk_en) begin
      if (reg_wr) begin
        case (reg_addr)
          `GPT_ADDR_CTRL:     ctrl      <= reg_wdata[6:0];
          `GPT_ADDR_PRESCALE: prescale  <= reg_wdata;
          `GPT_ADDR_MATCHCTL: match_ctl <= reg_wdata[11:0];
          `GPT_ADDR_CAPCTL:   cap_ctl   <= reg_wdata[11:0];
          `GPT_ADDR_EXTCTL:   ext_ctl   <= reg_wdata[7:0];
          `GPT_ADDR_PWMCTL: begin
            pwm_ctl <= reg_wdata[3:0];
            dma_en  <= reg_wdata[9:8];
          end
          `GPT_ADDR_MASK:     mask      <= reg_wdata[7:0];
          default: ;
        endcase
        if (is_bank(reg_addr, `GPT_ADDR_MATCH0) & (reg_addr[1:0] == 2'h0))
          match_shd[reg_addr[3:2]] <= reg_wdata;
      end
      // stop on match clears enable; a same-cycle write loses to it
      if (any_stop)
        ctrl[`GPT_CTRL_ENABLE] <= 1'b0;
      for (i_reg = 0; i_reg < 4; i_reg = i_reg + 1)
        if (cap_evt[i_reg])
          capt[i_reg] <= count;
      // set wins over write-one-to-clear
      status <= (status & ~(wr_stat ? reg_wdata[7:0] : 8'h00)) | evt_bits;
    end
  end

  // ----------------------------------------------------------------
  // outputs: match pins, pwm, dma, irq
  // ----------------------------------------------------------------
  // pwm channel: low from period start, high from its own match;
  // match 3, meant as the period match, is never a pwm channel
  always @(posedge clk_sys) begin
    if (reset) begin
      match_out <= 4'h0;
      dma_req   <= 2'h0;
      irq       <= 1'b0;
    end else if (clk_en) begin
      // a pwm channel ignores its output action field
      for (i_out = 0; i_out < 4; i_out = i_out + 1) begin
        if (pwm_ctl[i_out] & (i_out < 3)) begin
          if (hit[i_out])
            match_out[i_out] <= 1'b1;
          else if (period)
            match_out[i_out] <= 1'b0;
        end else if (hit[i_out]) begin
          case (ext_ctl[2*i_out +: 2])
            `GPT_EXT_LOW:    match_out[i_out] <= 1'b0;
            `GPT_EXT_HIGH:   match_out[i_out] <= 1'b1;
            `GPT_EXT_TOGGLE: match_out[i_out] <= ~match_out[i_out];
            default:         match_out[i_out] <= match_out[i_out];
          endcase
        end
      end
      // one-cycle pulses: a held request would start a second transfer
      dma_req <= hit[1:0] & dma_en;
      // irq lags status by a cycle; software must allow for it after a clear
      irq     <= |(status & mask);
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // read data lives one cycle and returns to zero, so no stale word lingers
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= `GPT_RST_WORD;
    end else if (clk_en) begin
      reg_rdata <= `GPT_RST_WORD;
      if (reg_rd) begin
        if (is_bank(reg_addr, `GPT_ADDR_MATCH0))
          reg_rdata <= match_shd[reg_addr[3:2]];
        else if (is_bank(reg_addr, `GPT_ADDR_CAPT0))
          reg_rdata <= capt[reg_addr[3:2]];
        else begin
          case (reg_addr)
            `GPT_ADDR_CTRL:     reg_rdata <= {25'h0, ctrl};
            `GPT_ADDR_COUNT:    reg_rdata <= count;
            `GPT_ADDR_PRESCALE: reg_rdata <= prescale;
            `GPT_ADDR_PRECNT:   reg_rdata <= precnt;
            `GPT_ADDR_MATCHCTL: reg_rdata <= {20'h0, match_ctl};
            `GPT_ADDR_CAPCTL:   reg_rdata <= {20'h0, cap_ctl};
            `GPT_ADDR_EXTCTL:   reg_rdata <= {24'h0, ext_ctl};
            `GPT_ADDR_PWMCTL:   reg_rdata <= {22'h0, dma_en, 4'h0, pwm_ctl};
            `GPT_ADDR_STATUS:   reg_rdata <= {24'h0, status};
            `GPT_ADDR_MASK:     reg_rdata <= {24'h0, mask};
            default:            reg_rdata <= `GPT_RST_WORD;
          endcase
        end
      end
    end
  end

endmodule

/* File: sim/gptmr_sva.sv */
// port checker for the timer/counter top
`timescale 1ns/100ps
`include "gptmr_regs.vh"
module gptmr_sva #(
  parameter NCAP = 4,
  parameter NMAT = 4
) (
  // clock, reset, enable
  input wire        clk_sys,
  input wire        reset,
  input wire        clk_en,
  // register port
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  // pins and system
  input wire        ext_clk,
  input wire [3:0]  cap_in,
  input wire [3:0]  match_out,
  input wire [1:0]  dma_req,
  input wire        irq
);
  // ----------------------------
  // mirrors of the gating fields
  // ----------------------------
  reg  [7:0] msk;
  reg  [1:0] ext;
  reg        pwm;
  reg  [1:0] den;
  // rebuilt from bus writes so every check stays at the ports
  always @(posedge clk_sys) begin
    if (reset) begin
      msk <= 8'h00;
      ext <= 2'h0;
      pwm <= 1'b0;
      den <= 2'h0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == `GPT_ADDR_MASK) msk <= reg_wdata[7:0];
      if (reg_addr == `GPT_ADDR_EXTCTL) ext <= reg_wdata[1:0];
      if (reg_addr == `GPT_ADDR_PWMCTL) pwm <= reg_wdata[0];
      if (reg_addr == `GPT_ADDR_PWMCTL) den <= reg_wdata[9:8];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_hold_frozen: assert property (!clk_en |=> $stable(match_out) && $stable(irq))
    else $error("outputs moved while frozen");
  a_reset_quiet: assert property ($past(reset) |-> match_out == 4'h0 && dma_req == 2'h0 && !irq)
    else $error("outputs not idle after reset");
  a_dma_gate: assert property ((dma_req & ~$past(den)) == 2'h0)
    else $error("dma request while disabled");
  a_irq_masked: assert property (msk == 8'h00 && $past(msk) == 8'h00 |-> !irq)
    else $error("interrupt with all sources masked");
  a_irq_cause: assert property ($rose(irq) |-> $past(msk) != 8'h00)
    else $error("interrupt rose without a mask bit");
  a_ext_rise: assert property ($rose(match_out[0]) && !$past(reset) |->
    $past(pwm) || $past(ext) == `GPT_EXT_HIGH || $past(ext) == `GPT_EXT_TOGGLE)
    else $error("match output rose against its action");
  a_ext_fall: assert property ($fell(match_out[0]) && !$past(reset) |->
    $past(pwm) || $past(ext) == `GPT_EXT_LOW || $past(ext) == `GPT_EXT_TOGGLE)
    else $error("match output fell against its action");
  c_dma: cover property (dma_req[0]);
  c_irq: cover property ($rose(irq));
  c_out: cover property ($rose(match_out[0]));
  c_pwm: cover property ($rose(match_out[1]));
endmodule
bind gptmr_top gptmr_sva #(.NCAP(NCAP), .NMAT(NMAT)) u_sva (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_clk(ext_clk), .cap_in(cap_in), .match_out(match_out), .dma_req(dma_req), .irq(irq));

/* File: sim/gptmr_pins.sv */
// pin side model: external count clock and capture inputs
`timescale 1ns/100ps
module gptmr_pins (
  // clock
  input wire       clk_sys,
  // pins
  output reg       ext_clk,
  output reg [3:0] cap_in
);
  // pins rest low; every ext_clk level lasts four cycles so the synchroniser never drops one
  initial begin
    ext_clk = 1'b0;
    cap_in = 4'h0;
  end
  task ext_pulses(input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) begin
      repeat (4) @(posedge clk_sys);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_clk <= 1'b0;
    end
  endtask
  task cap_edge(input integer c);
    @(posedge clk_sys);
    cap_in[c] <= ~cap_in[c];
  endtask
endmodule

/* File: sim/gptmr_top_tb.sv */
// self-checking bench of the timer/counter
`timescale 1ns/100ps
`include "gptmr_regs.vh"
module gptmr_top_tb;
  reg         clk_sys = 1'b0;
  reg         reset = 1'b1;
  reg         clk_en = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  wire [31:0] reg_rdata;
  wire        ext_clk;
  wire [3:0]  cap_in;
  wire [3:0]  match_out;
  wire [1:0]  dma_req;
  wire        irq;
  integer     errors = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     i;
  reg  [31:0] a;
  reg  [31:0] b;
  always #12.5 clk_sys = ~clk_sys;
  gptmr_top dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_clk(ext_clk), .cap_in(cap_in), .match_out(match_out), .dma_req(dma_req), .irq(irq));
  gptmr_pins pins (.clk_sys(clk_sys), .ext_clk(ext_clk), .cap_in(cap_in));
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] ad, input [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data is taken one ns after the edge that answers the strobe
  task rd(input [7:0] ad, output [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task run(input [31:0] pre, input [31:0] m0, input [31:0] mc, input [31:0] ctl);
    wr(`GPT_ADDR_CTRL, 32'h2);
    wr(`GPT_ADDR_PRESCALE, pre);
    wr(`GPT_ADDR_MATCH0, m0);
    wr(`GPT_ADDR_MATCHCTL, mc);
    wr(`GPT_ADDR_CTRL, ctl);
  endtask
  task t_reset;
    rd(`GPT_ADDR_MATCH0, a);
    chk("match0", `GPT_RST_MATCH, a);
    wr(8'h2C, 32'hFFFF_FFFF);
    rd(8'h2C, a);
    chk("unmapped", 32'h0, a);
    $display("test reset done");
  endtask
  // a frozen clock enable must cost the counter exactly the frozen edges
  task t_prescale;
    run(32'h0, `GPT_RST_MATCH, 32'h0, 32'h1);
    rd(`GPT_ADDR_COUNT, a);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (20) @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(`GPT_ADDR_COUNT, b);
    chk("freeze", 32'h3, b - a);
    run(32'h3, `GPT_RST_MATCH, 32'h0, 32'h1);
    rd(`GPT_ADDR_COUNT, a);
    repeat (38) @(posedge clk_sys);
    rd(`GPT_ADDR_COUNT, b);
    chk("rate", 32'hA, b - a);
    $display("test prescale done");
  endtask
  task t_modes;
    for (i = 1; i < 4; i = i + 1) begin
      run(32'h0, `GPT_RST_MATCH, 32'h0, 32'h1 | (i << 2));
      rd(`GPT_ADDR_COUNT, a);
      pins.ext_pulses(5);
      repeat (6) @(posedge clk_sys);
      rd(`GPT_ADDR_COUNT, b);
      chk("edges", (i == 3) ? 32'hA : 32'h5, b - a);
    end
    $display("test modes done");
  endtask
  task t_match;
    wr(`GPT_ADDR_MASK, 32'h1);
    wr(`GPT_ADDR_PWMCTL, 32'h100);
    run(32'h0, 32'h2, 32'h3, 32'h1);
    for (i = 0; i < 6; i = i + 1) begin
      rd(`GPT_ADDR_COUNT, a);
      chk("wrapped", 32'h1, {31'h0, a < 32'h3});
    end
    chk("irq", 32'h1, {31'h0, irq});
    i = 0;
    while (dma_req[0] !== 1'b1 && i < 8) begin
      @(posedge clk_sys);
      #1 i = i + 1;
    end
    chk("dma", 32'h1, {31'h0, dma_req[0]});
    for (i = 0; i < 4; i = i + 1) begin
      wr(`GPT_ADDR_EXTCTL, i);
      repeat (12) @(posedge clk_sys);
      #1 a = {31'h0, match_out[0]};
      repeat (3) @(posedge clk_sys);
      #1 b = (i == 0) ? a : (i == 1) ? 32'h0 : (i == 2) ? 32'h1 : {31'h0, ~a[0]};
      chk("extout", b, {31'h0, match_out[0]});
    end
    wr(`GPT_ADDR_PWMCTL, 32'h0);
    wr(`GPT_ADDR_MASK, 32'h0);
    $display("test match done");
  endtask
  task t_stop;
    run(32'h0, 32'h5, 32'h4, 32'h1);
    repeat (20) @(posedge clk_sys);
    rd(`GPT_ADDR_CTRL, a);
    chk("stopped", 32'h0, {31'h0, a[0]});
    rd(`GPT_ADDR_COUNT, a);
    rd(`GPT_ADDR_COUNT, b);
    chk("held", a, b);
    $display("test stop done");
  endtask
  task t_capture;
    wr(`GPT_ADDR_CAPCTL, 32'h5);
    wr(`GPT_ADDR_MASK, 32'h10);
    run(32'h0, `GPT_RST_MATCH, 32'h0, 32'h1);
    repeat (30) @(posedge clk_sys);
    pins.cap_edge(0);
    repeat (8) @(posedge clk_sys);
    #1 chk("capirq", 32'h1, {31'h0, irq});
    rd(`GPT_ADDR_CAPT0, a);
    chk("capt", 32'h1, {31'h0, a > 32'h14 && a < 32'h3C});
    wr(`GPT_ADDR_STATUS, 32'h10);
    wr(`GPT_ADDR_CAPCTL, 32'h3);
    wr(`GPT_ADDR_CTRL, 32'h11);
    repeat (40) @(posedge clk_sys);
    pins.cap_edge(0);
    repeat (8) @(posedge clk_sys);
    rd(`GPT_ADDR_COUNT, a);
    chk("cleared", 32'h1, {31'h0, a < 32'h10});
    $display("test capture done");
  endtask
  // one eight-cycle period: high time of output 1 and dma pulses of match 1
  task pwm_window(output [31:0] hi, output [31:0] dq);
    integer n;
    begin
      hi = 32'h0;
      dq = 32'h0;
      for (n = 0; n < 8; n = n + 1) begin
        @(posedge clk_sys);
        #1 hi = hi + match_out[1];
        dq = dq + dma_req[1];
      end
    end
  endtask
  // match 3 resets at 7 for an eight-cycle period; output 1 duty follows its shadow
  task t_pwm;
    wr(`GPT_ADDR_CTRL, 32'h2);
    wr(`GPT_ADDR_PRESCALE, 32'h0);
    wr(`GPT_ADDR_MATCH0 + 8'h4, 32'h3);
    wr(`GPT_ADDR_MATCH0 + 8'hC, 32'h7);
    wr(`GPT_ADDR_MATCHCTL, 32'h400);
    wr(`GPT_ADDR_PWMCTL, 32'h202);
    wr(`GPT_ADDR_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    pwm_window(a, b);
    chk("pwmhigh", 32'h4, a);
    chk("dma1", 32'h1, b);
    wr(`GPT_ADDR_MATCH0 + 8'h4, 32'h5);
    repeat (20) @(posedge clk_sys);
    pwm_window(a, b);
    chk("pwmduty", 32'h2, a);
    wr(`GPT_ADDR_PWMCTL, 32'h0);
    wr(`GPT_ADDR_CTRL, 32'h2);
    $display("test pwm done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // whole run needs about 600 cycles; the ceiling leaves a wide margin
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      test_done;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_prescale;
    t_modes;
    t_match;
    t_stop;
    t_capture;
    t_pwm;
    test_done;
  end
endmodule
